// file: src/frmc_pkg.sv
package frmc_pkg;
  // ---------------------------------------------------------------
  // command codes written on the flash data bus
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_QUERY        = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_MULTI_WRITE  = 8'hE8;
  // ---------------------------------------------------------------
  // identifier and query offsets (word addresses), status and block status bit positions
  // ---------------------------------------------------------------
  localparam logic [20:0] ID_MFR_ADDR     = 21'h000000;
  localparam logic [20:0] ID_DEV_ADDR     = 21'h000002;
  localparam logic [15:0] BLK_STATUS_OFS  = 16'h0004;
  localparam logic [15:0] QRY_BLK_OFS     = 16'h0002;
  localparam int          SR_READY_BIT    = 7;
  localparam int          SR_FAIL5_BIT    = 5;
  localparam int          SR_FAIL4_BIT    = 4;
  localparam int          SR_FAIL3_BIT    = 3;
  localparam int          SR_FAIL1_BIT    = 1;
  localparam int          BS_LOCK_BIT     = 0;
  localparam int          BS_ERASE_BIT    = 1;
  // ---------------------------------------------------------------
  // controller register map (own port)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_DATA   = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_MODE   = 4'h4;
  localparam logic [3:0] OP_WRITE   = 4'h1;
  localparam logic [3:0] OP_READ    = 4'h2;
  // ---------------------------------------------------------------
  // bus timing: phases in clk cycles
  // ---------------------------------------------------------------
  localparam int T_SETUP_NS  = 20;
  localparam int T_STROBE_NS = 100;
  localparam int T_HOLD_NS   = 20;
  localparam int CLK_NS      = 10;
  localparam logic [7:0] SETUP_CYC  = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC   = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  // tracked device read mode
  typedef enum logic [2:0] {MD_ARRAY, MD_ID, MD_STATUS, MD_XSTATUS, MD_QUERY} frmc_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} frmc_state_t;
endpackage

// file: src/frmc_host.sv
`timescale 1ns/10ps
module frmc_host
  import frmc_pkg::*;
#(
  parameter int AW = 21
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // software register port
  input  wire logic [3:0]    regAddr,
  input  wire logic [31:0]   regWdata,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [31:0]   regRdata,
  // flash pins
  output logic [AW-1:0]      flashAddr,
  output logic [15:0]        flashDqOut,
  output logic               flashDqOe,
  input  wire logic [15:0]   flashDqIn,
  output logic               chipEnableN,
  output logic               outputEnableN,
  output logic               writeEnableN,
  output logic               resetPowerdownN,
  output logic               byteWidthN
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [AW-1:0]  addr_reg;        // target address
  logic [15:0]    wdata_reg;       // command / data to write
  logic [15:0]    rdata_reg;       // last captured read
  logic           busy_reg;        // cycle in progress
  logic           rstPin_reg;      // reset/power-down drive
  logic           byteMode_reg;    // byte-wide selection
  logic           isWrite_reg;     // current cycle is a write
  logic           devBusy_reg;     // device reported not ready
  logic [7:0]     cnt_reg;         // phase counter
  frmc_state_t    state_reg;       // bus cycle state
  frmc_mode_t     mode_reg;        // tracked device read mode
  logic [15:0]    dqSync1_reg;     // data input first stage
  logic [15:0]    dqSync2_reg;     // data input second stage
  logic           rdDone_reg;      // one read completed since last command
  logic           staleRead_reg;   // extended status read repeated after its command

  wire startOp = regWr && (regAddr == REG_CTRL) && !busy_reg;
  wire [7:0] cmdByte = wdata_reg[7:0];

  // ---------------------------------------------------------------
  // data input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dqSync1_reg <= 16'h0000;
      dqSync2_reg <= 16'h0000;
    end else begin
      dqSync1_reg <= flashDqIn;
      dqSync2_reg <= dqSync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // software-written setup registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg     <= '0;
      wdata_reg    <= 16'h0000;
      rstPin_reg   <= 1'b0;
      byteMode_reg <= 1'b0;
    end else if (regWr && !busy_reg) begin
      case (regAddr)
        REG_ADDR: addr_reg  <= regWdata[AW-1:0];
        REG_DATA: wdata_reg <= regWdata[15:0];
        REG_MODE: begin
          // device leaves power-down in array mode
          rstPin_reg   <= regWdata[0];
          byteMode_reg <= regWdata[1];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus cycle sequencer: setup, strobe, hold
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 8'h00;
      busy_reg    <= 1'b0;
      isWrite_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // commands only issued with reset pin high
          if (startOp && rstPin_reg) begin
            isWrite_reg <= (regWdata[3:0] == OP_WRITE);
            busy_reg    <= 1'b1;
            cnt_reg     <= SETUP_CYC;
            state_reg   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            cnt_reg   <= STROBE_CYC;
            state_reg <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            cnt_reg   <= HOLD_CYC;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            busy_reg  <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drive: strobes rise at the end of the strobe phase, before hold
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chipEnableN     <= 1'b1;
      outputEnableN   <= 1'b1;
      writeEnableN    <= 1'b1;
      flashDqOe       <= 1'b0;
      flashDqOut      <= 16'h0000;
      flashAddr       <= '0;
      resetPowerdownN <= 1'b0;
      byteWidthN      <= 1'b1;
    end else begin
      resetPowerdownN <= rstPin_reg;
      byteWidthN      <= !byteMode_reg;
      flashAddr       <= addr_reg;
      flashDqOut      <= wdata_reg;
      // command is single write; latched on WE rising
      chipEnableN   <= !(state_reg == ST_STROBE && cnt_reg != 8'h01);
      writeEnableN  <= !(isWrite_reg && state_reg == ST_STROBE && cnt_reg != 8'h01);
      // strobe returns high every read so status refreshes
      outputEnableN <= !(!isWrite_reg && state_reg == ST_STROBE && cnt_reg != 8'h01);
      flashDqOe     <= isWrite_reg && state_reg != ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // read capture at end of strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (!isWrite_reg && state_reg == ST_HOLD && cnt_reg == HOLD_CYC) begin
      case (mode_reg)
        // query data on low byte only
        MD_QUERY: rdata_reg <= {8'h00, dqSync2_reg[7:0]};
        MD_ID:    rdata_reg <= byteMode_reg ? {8'h00, dqSync2_reg[7:0]} : dqSync2_reg;
        default:  rdata_reg <= dqSync2_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // device status tracking from status reads
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      devBusy_reg <= 1'b0;
    end else if (!isWrite_reg && state_reg == ST_HOLD && cnt_reg == HOLD_CYC && mode_reg == MD_STATUS) begin
      // ready bit gates the read array command
      devBusy_reg <= !dqSync2_reg[SR_READY_BIT];
    end
  end

  // ---------------------------------------------------------------
  // tracked device mode follows commands written
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MD_ARRAY;
    end else if (!rstPin_reg) begin
      mode_reg <= MD_ARRAY;
    end else if (isWrite_reg && state_reg == ST_HOLD && cnt_reg == HOLD_CYC) begin
      case (cmdByte)
        // array command ignored while write machine busy
        CMD_READ_ARRAY:  if (!devBusy_reg) mode_reg <= MD_ARRAY;
        CMD_READ_ID:     mode_reg <= MD_ID;
        CMD_READ_STATUS: mode_reg <= MD_STATUS;
        CMD_MULTI_WRITE: mode_reg <= MD_XSTATUS;
        CMD_QUERY:       mode_reg <= MD_QUERY;
        CMD_CLEAR_STATUS: ;
        default:         ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // repeated read bookkeeping for extended status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdDone_reg    <= 1'b0;
      staleRead_reg <= 1'b0;
    end else if (state_reg == ST_HOLD && cnt_reg == HOLD_CYC) begin
      rdDone_reg    <= !isWrite_reg;
      // extended status does not refresh on reads
      staleRead_reg <= !isWrite_reg && rdDone_reg && mode_reg == MD_XSTATUS;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        REG_ADDR:   regRdata <= 32'(addr_reg);
        REG_DATA:   regRdata <= {16'h0000, rdata_reg};
        // stale flag, tracked mode, device busy and cycle busy
        REG_STATUS: regRdata <= {24'h000000, 1'b0, staleRead_reg, 3'(mode_reg),
                                 devBusy_reg, 1'b0, busy_reg};
        REG_MODE:   regRdata <= {30'h00000000, byteMode_reg, rstPin_reg};
        default:    regRdata <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // write strobe only inside a chip-enabled cycle
  a_we_ce_pair: assert property (@(posedge clk) disable iff (rst)
    !writeEnableN |-> !chipEnableN) else $error("write strobe without chip enable");
  // read strobe only inside a chip-enabled cycle
  a_oe_ce_pair: assert property (@(posedge clk) disable iff (rst)
    !outputEnableN |-> !chipEnableN) else $error("read strobe without chip enable");
  // read and write strobes never low together
  a_strobe_excl: assert property (@(posedge clk) disable iff (rst)
    !writeEnableN |-> outputEnableN) else $error("read and write strobes overlap");
  // no command while the device is held in power-down
  a_no_cmd_reset: assert property (@(posedge clk) disable iff (rst)
    !writeEnableN |-> resetPowerdownN) else $error("command with reset pin low");
  // a finished read strobe stays high for at least one more cycle
  a_oe_toggles: assert property (@(posedge clk) disable iff (rst)
    $rose(outputEnableN) |=> outputEnableN) else $error("read strobe not returned high");
  // each command is one write pulse, low for nine sampled cycles
  a_we_single: assert property (@(posedge clk) disable iff (rst)
    $fell(writeEnableN) |-> ##8 !writeEnableN ##1 writeEnableN) else $error("write pulse length wrong");
  // tracked mode follows status and query commands
  a_status_mode: assert property (@(posedge clk) disable iff (rst)
    (isWrite_reg && state_reg == ST_HOLD && cnt_reg == HOLD_CYC && cmdByte == CMD_READ_STATUS && rstPin_reg)
    |=> mode_reg == MD_STATUS) else $error("status mode not entered");
  a_query_mode: assert property (@(posedge clk) disable iff (rst)
    (isWrite_reg && state_reg == ST_HOLD && cnt_reg == HOLD_CYC && cmdByte == CMD_QUERY && rstPin_reg)
    |=> mode_reg == MD_QUERY) else $error("query mode not entered");
  // array command refused while the device last reported busy
  a_array_busy: assert property (@(posedge clk) disable iff (rst)
    (isWrite_reg && state_reg == ST_HOLD && cnt_reg == HOLD_CYC && cmdByte == CMD_READ_ARRAY && devBusy_reg
     && mode_reg != MD_ARRAY) |=> mode_reg != MD_ARRAY) else $error("array taken while busy");
  // query results never carry a high byte
  a_query_low: assert property (@(posedge clk) disable iff (rst)
    (mode_reg == MD_QUERY && !isWrite_reg && state_reg == ST_HOLD && cnt_reg == HOLD_CYC)
    |=> rdata_reg[15:8] == 8'h00) else $error("query high byte not zero");
  // data lines released whenever the read strobe is low
  a_dq_released: assert property (@(posedge clk) disable iff (rst)
    !outputEnableN |-> !flashDqOe) else $error("bus driven during read");
endmodule

// file: test/frmc_flash_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// flash device model: command decode and read mode selection
// ----------------------------------------------------------------
module frmc_flash_model
  import frmc_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h3C,  // arbitrary maker code
  parameter logic [7:0] DEV_CODE = 8'h5A   // arbitrary device code
) (
  // flash pins
  input  wire logic [20:0] addr,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        rpN,
  input  wire logic        byteN,
  input  wire logic [15:0] dqIn,
  output logic      [15:0] dqOut,
  output logic             dqDrv,
  // write engine state, set by the bench
  input  wire logic        busy,
  input  wire logic        failSet,
  input  wire logic [7:0]  xsr
);
  frmc_mode_t  mode     = MD_ARRAY;  // array mode from power-up
  logic [3:0]  fails    = 4'h0;      // sticky fail flags 5,4,3,1
  logic [7:0]  srLatch  = 8'h00;     // status output latch
  logic [7:0]  xsrLatch = 8'h00;     // extended status latch
  logic [15:0] lastVal  = 16'h0000;  // last value put on the bus
  logic [15:0] rdVal;                // value of the current read
  logic [15:0] ofs;                  // query or identifier offset
  logic [7:0]  srNow;                // live status byte
  logic [7:0]  blk;                  // block status: odd blocks locked, bit1 erase failed
  wire         wrAct = ~ceN & ~weN & rpN;  // bus write in progress
  assign srNow = {~busy, 1'b0, fails[3:1], 1'b0, fails[0], 1'b0};
  assign blk   = {6'h00, addr[17:16]};
  assign ofs   = byteN ? addr[15:0] : {1'b0, addr[15:1]};
  assign dqDrv = ~ceN & ~oeN & rpN;
  // low byte driven while selected; upper byte left floating in byte mode
  assign dqOut = {(dqDrv && byteN) ? rdVal[15:8] : ~lastVal[15:8], dqDrv ? rdVal[7:0] : ~lastVal[7:0]};
  // read data by mode
  always_comb begin
    case (mode)
      MD_ID:      rdVal = ofs == 16'h0000 ? {8'h00, MFR_CODE} : ofs == 16'h0002 ? {8'h00, DEV_CODE} :
                          ofs == BLK_STATUS_OFS ? {8'h00, blk} : 16'h0000;
      MD_STATUS:  rdVal = {8'h00, srLatch};
      MD_XSTATUS: rdVal = {8'h00, xsrLatch};
      MD_QUERY:   rdVal = ofs == QRY_BLK_OFS ? {8'h00, blk} : ofs == 16'h0010 ? 16'h0051 :
                          ofs == 16'h0011 ? 16'h0052 : ofs == 16'h0012 ? 16'h0059 : 16'h0000;
      default:    rdVal = addr[15:0] ^ 16'hA5C3;
    endcase
  end
  // status captured once per read, as the later of the two strobes falls
  always @(posedge dqDrv) begin
    srLatch <= srNow;
  end
  // remember what was driven so a released bus shows something else
  always @(posedge oeN) begin
    lastVal <= rdVal;
  end
  // fail flags: set by the engine, cleared by 50H only when idle
  always @(negedge wrAct or posedge failSet) begin
    if (failSet) fails <= 4'hF;
    else if (dqIn[7:0] == CMD_CLEAR_STATUS && !busy) fails <= 4'h0;
  end
  // command decode on the first rising write strobe
  always @(negedge wrAct or negedge rpN) begin
    if (!rpN) mode <= MD_ARRAY;
    else begin
      case (dqIn[7:0])
        CMD_READ_ARRAY:  if (!busy) mode <= MD_ARRAY;
        CMD_READ_ID:     mode <= MD_ID;
        CMD_READ_STATUS: mode <= MD_STATUS;
        CMD_QUERY:       mode <= MD_QUERY;
        CMD_MULTI_WRITE: begin
          mode     <= MD_XSTATUS;
          xsrLatch <= xsr;
        end
        default: ;
      endcase
    end
  end
endmodule

// file: test/frmc_host_test.sv
`timescale 1ns/10ps
module frmc_host_test;
  import frmc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, busy = 1'b0, failSet = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, v;
  logic [7:0]  xsr = 8'h80;
  logic [20:0] flashAddr, a;
  logic [15:0] flashDqOut, mdlDq, dqBus;
  logic        flashDqOe, ceN, oeN, weN, rpN, byteN, mdlDrv;
  int          err_total = 0, samples_checked = 0, cyc = 0, o;
  always #5 clk = ~clk;
  assign dqBus = mdlDrv ? mdlDq : flashDqOe ? flashDqOut : mdlDq;
  frmc_host dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(dqBus),
    .chipEnableN(ceN), .outputEnableN(oeN), .writeEnableN(weN), .resetPowerdownN(rpN), .byteWidthN(byteN));
  frmc_flash_model mdl_u (.addr(flashAddr), .ceN(ceN), .oeN(oeN), .weN(weN), .rpN(rpN), .byteN(byteN),
    .dqIn(dqBus), .dqOut(mdlDq), .dqDrv(mdlDrv), .busy(busy), .failSet(failSet), .xsr(xsr));
  // ----------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] qryExp(input int q);
    return q == 16 ? 32'h51 : q == 17 ? 32'h52 : q == 18 ? 32'h59 : 32'h0;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic regWrite(input logic [3:0] ra, input logic [31:0] d);
    @(posedge clk) {regAddr, regWdata, regWr} <= {ra, d, 1'b1};
    @(posedge clk) regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] ra, output logic [31:0] d);
    @(posedge clk) {regAddr, regRd} <= {ra, 1'b1};
    @(posedge clk) regRd <= 1'b0;
    @(negedge clk) d = regRdata;
  endtask
  task automatic flashOp(input logic [3:0] op, input logic [20:0] fa, input logic [7:0] d);
    logic [31:0] s;
    regWrite(REG_ADDR, {11'h0, fa});
    regWrite(REG_DATA, {24'h0, d});
    regWrite(REG_CTRL, {28'h0, op});
    s = 32'h1;
    for (int i = 0; i < 40 && s[0] !== 1'b0; i++) regRead(REG_STATUS, s);
    check("cycle done", {31'h0, s[0]}, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] c);
    flashOp(OP_WRITE, 21'($urandom), c);
  endtask
  task automatic rd(input logic [20:0] fa, input logic [31:0] exp, input string name);
    flashOp(OP_READ, fa, 8'h00);
    regRead(REG_DATA, v);
    check(name, v, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    v = $urandom(32'hF4AB25DC);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) check("reset pin", {31'h0, rpN}, 32'h0);
    regWrite(REG_MODE, 32'h1);
    repeat (2) @(negedge clk);
    check("reset pin", {31'h0, rpN}, 32'h1);
    regRead(4'hF, v);
    check("unmapped", v, 32'h0);
    repeat (4) begin
      a = 21'($urandom);
      rd(a, {16'h0, a[15:0] ^ 16'hA5C3}, "array");
    end
    cmd(CMD_READ_ID);
    rd(ID_MFR_ADDR, 32'h3C, "maker code");
    rd(ID_DEV_ADDR, 32'h5A, "device code");
    repeat (3) begin
      a = {5'($urandom), BLK_STATUS_OFS};
      rd(a, {30'h0, a[17:16]}, "id block status");
    end
    cmd(CMD_READ_STATUS);
    rd(21'($urandom), 32'h80, "status");
    @(posedge clk) failSet <= 1'b1;
    @(posedge clk) failSet <= 1'b0;
    rd(21'($urandom), 32'hBA, "status fails");
    cmd(CMD_CLEAR_STATUS);
    rd(21'($urandom), 32'h80, "status cleared");
    @(posedge clk) {failSet, busy} <= 2'b11;
    @(posedge clk) failSet <= 1'b0;
    rd(21'($urandom), 32'h3A, "status busy");
    regRead(REG_STATUS, v);
    check("device busy", {31'h0, v[2]}, 32'h1);
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_READ_ARRAY);
    rd(21'($urandom), 32'h3A, "busy ignores");
    @(posedge clk) busy <= 1'b0;
    rd(21'($urandom), 32'hBA, "sticky fails");
    cmd(CMD_READ_ARRAY);
    a = 21'($urandom);
    rd(a, {16'h0, a[15:0] ^ 16'hA5C3}, "array again");
    cmd(CMD_MULTI_WRITE);
    rd(21'($urandom), 32'h80, "xstatus");
    @(posedge clk) xsr <= 8'h00;
    rd(21'($urandom), 32'h80, "xstatus held");
    regRead(REG_STATUS, v);
    check("stale xstatus", {31'h0, v[6]}, 32'h1);
    cmd(CMD_MULTI_WRITE);
    rd(21'($urandom), 32'h00, "xstatus new");
    cmd(CMD_QUERY);
    regRead(REG_STATUS, v);
    check("mode query", {29'h0, v[5:3]}, {29'h0, 3'(MD_QUERY)});
    for (int i = 0; i < 12; i++) begin
      o = i < 5 ? (i == 4 ? 63 : 16 + i) : int'($urandom_range(63));
      rd(21'(o), qryExp(o), "query word");
    end
    a = {5'($urandom), QRY_BLK_OFS};
    rd(a, {30'h0, a[17:16]}, "query block status");
    regWrite(REG_MODE, 32'h3);
    repeat (2) @(negedge clk);
    check("byte pin", {31'h0, byteN}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      o = i < 3 ? 16 + i : int'($urandom_range(63));
      rd({14'h0, 6'(o), 1'($urandom)}, qryExp(o), "query byte");
    end
    cmd(CMD_READ_ID);
    rd({ID_DEV_ADDR[19:0], 1'b0}, 32'h5A, "byte device code");
    regWrite(REG_MODE, 32'h0);
    regWrite(REG_MODE, 32'h1);
    a = 21'($urandom);
    rd(a, {16'h0, a[15:0] ^ 16'hA5C3}, "array after powerdown");
    tally_and_finish();
  end
endmodule
